// ---- dv/limit_bin_output_checker.sv ----
// Purpose: Port assertions for limit_bin_output
// Assumes: Register writes shadowed from the bus
// Notes:   Clear effects given two cycles to land
`timescale 1ns/1ps
`default_nettype none
`include "limit_bin_defs.svh"
module limit_bin_output_checker (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic        result_valid_i,
  input wire logic [6:0]  cur_slot_i,
  input wire logic        seq_start_i,
  input wire logic        sweep_end_i,
  input wire logic [3:0]  port_pattern_value_o,
  input wire logic [6:0]  next_slot_o,
  input wire logic        next_slot_valid_o,
  input wire logic        result_fail_o
);
  logic        dp_reg;
  logic [7:0]  dp_addr_reg;
  logic [15:0] ctrl_reg;
  logic [3:0]  dflt_reg;
  logic [6:0]  pslot_reg;
  logic [6:0]  fslot_reg;
  logic [2:0]  idle_reg;
  logic        latched_reg;
  logic        clr_wr;
  logic        slot_ok;
  logic        ev;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  assign slot_ok = (hwdata_i[31:7] == 25'h0) && (hwdata_i[6:0] <= `SLOT_MAX);
  assign clr_wr  = dp_reg && (dp_addr_reg == `OFF_CLEAR) && hwdata_i[0];
  assign ev      = result_valid_i || seq_start_i || sweep_end_i || dp_reg || (hsel_i && htrans_i[1]);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dp_reg      <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_reg      <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      dp_addr_reg <= haddr_i[7:0];
    end
  end
  // Shadow mirrors the slot refusal, or branch checks would go stale
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg  <= `CTRL_RESET;
      dflt_reg  <= `DEFAULT_LVL_RST;
      pslot_reg <= `SLOT_NEXT;
      fslot_reg <= `SLOT_NEXT;
    end else if (dp_reg) begin
      if (dp_addr_reg == `OFF_CTRL) ctrl_reg <= hwdata_i[15:0];
      if (dp_addr_reg == `OFF_DEFAULT_LVL) dflt_reg <= hwdata_i[3:0];
      if (dp_addr_reg == `OFF_PASS_SLOT && slot_ok) begin
        pslot_reg <= hwdata_i[6:0];
        if (hwdata_i[6:0] != `SLOT_NEXT) fslot_reg <= `SLOT_NEXT;
      end
      if (dp_addr_reg == `OFF_FAIL_SLOT && slot_ok) begin
        fslot_reg <= hwdata_i[6:0];
        if (hwdata_i[6:0] != `SLOT_NEXT) pslot_reg <= `SLOT_NEXT;
      end
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_reg    <= 3'h0;
      latched_reg <= 1'b0;
    end else begin
      idle_reg <= ev ? 3'h0 : ((idle_reg == 3'h4) ? idle_reg : idle_reg + 3'h1);
      if (clr_wr || (seq_start_i && ctrl_reg[`CTRL_AUTO_BIT])) latched_reg <= 1'b0;
      else if (next_slot_valid_o && result_fail_o && !ctrl_reg[`CTRL_END_BIT]) latched_reg <= 1'b1;
    end
  end
  a_slot_default: assert property (result_valid_i && pslot_reg == 7'h00 && fslot_reg == 7'h00
    |=> next_slot_o == 7'($past(cur_slot_i) + 7'h01)) else $error("slot not plus one");
  a_pass_branch: assert property (result_valid_i && pslot_reg != 7'h00 |=> next_slot_o ==
    (result_fail_o ? 7'($past(cur_slot_i) + 7'h01) : $past(pslot_reg))) else $error("pass branch wrong");
  a_fail_branch: assert property (result_valid_i && fslot_reg != 7'h00 |=> next_slot_o ==
    (result_fail_o ? $past(fslot_reg) : 7'($past(cur_slot_i) + 7'h01))) else $error("fail branch wrong");
  a_port_quiet: assert property (idle_reg == 3'h4 |-> $stable(port_pattern_value_o))
    else $error("port moved idle");
  a_first_fail_holds: assert property (latched_reg && result_valid_i && idle_reg == 3'h4
    && !ctrl_reg[`CTRL_END_BIT] |=> $stable(port_pattern_value_o)) else $error("port moved");
  a_end_hold: assert property (ctrl_reg[`CTRL_END_BIT] && result_valid_i && !sweep_end_i
    |=> $stable(port_pattern_value_o)) else $error("end port moved");
  a_clear_default: assert property (clr_wr && !result_valid_i |-> ##[1:2] port_pattern_value_o == dflt_reg)
    else $error("no default after clear");
  a_auto_clear: assert property (seq_start_i && ctrl_reg[`CTRL_AUTO_BIT] && !result_valid_i
    |-> ##[1:2] port_pattern_value_o == dflt_reg) else $error("no default after start");
  a_narrow_line4: assert property (next_slot_valid_o && !ctrl_reg[`CTRL_WIDE_BIT]
    && !ctrl_reg[`CTRL_END_BIT] |-> !port_pattern_value_o[3]) else $error("line 4 driven");
  c_pass_jump: cover property (result_valid_i && pslot_reg != 7'h00);
  c_end_release: cover property (sweep_end_i && ctrl_reg[`CTRL_END_BIT]);
  c_auto_clear: cover property (seq_start_i && ctrl_reg[`CTRL_AUTO_BIT]);
endmodule : limit_bin_output_checker
bind limit_bin_output limit_bin_output_checker chk (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .result_valid_i, .cur_slot_i, .seq_start_i, .sweep_end_i,
  .port_pattern_value_o, .next_slot_o, .next_slot_valid_o, .result_fail_o);
`default_nettype wire

// ---- dv/limit_bin_output_tb.sv ----
// Purpose: Self-checking bench for limit_bin_output
// Assumes: Zero wait state slave
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "limit_bin_defs.svh"
module limit_bin_output_tb;
  import limit_bin_pkg::*;
  localparam logic [3:0] dflt = 4'h2;
  logic            clk_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic            hsel_i = 1'b0;
  logic [31:0]     haddr_i = 32'h0;
  logic [1:0]      htrans_i = 2'h0;
  logic            hwrite_i = 1'b0;
  logic [31:0]     hwdata_i = 32'h0;
  logic [31:0]     hrdata_o;
  logic            hreadyout_o;
  logic            hresp_o;
  logic            result_valid_i;
  test_result_type result_i;
  logic [6:0]      cur_slot_i;
  logic            seq_start_i;
  logic            sweep_end_i;
  logic [3:0]      port_pattern_value_o;
  logic [6:0]      next_slot_o;
  logic            next_slot_valid_o;
  logic            result_fail_o;
  int              mismatches = 0;
  int              n_checks = 0;
  limit_bin_output DUT (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .result_valid_i, .result_i, .cur_slot_i,
    .seq_start_i, .sweep_end_i, .port_pattern_value_o, .next_slot_o, .next_slot_valid_o, .result_fail_o);
  sweep_sequencer_model seq (.clk_i, .result_valid_o(result_valid_i), .result_o(result_i),
    .cur_slot_o(cur_slot_i), .seq_start_o(seq_start_i), .sweep_end_o(sweep_end_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic is_wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= is_wr;
    haddr_i <= {24'h000000, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(a, 1'b1, d, unused);
  endtask : reg_wr
  task automatic reg_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(a, 1'b0, 32'h0, d);
    check(what, d, exp);
  endtask : reg_rd
  task automatic settle_port(input string what, input logic [3:0] exp);
    @(posedge clk_i);
    #1;
    check(what, 32'(port_pattern_value_o), 32'(exp));
  endtask : settle_port
  task automatic clear_port;
    reg_wr(`OFF_CLEAR, 32'h1);
    @(posedge clk_i);
    settle_port("port after clear", dflt);
  endtask : clear_port
  task automatic restart(input logic [3:0] exp);
    seq.pulse(1'b0);
    settle_port("port after start", exp);
  endtask : restart
  // Reading sent, then judged
  task automatic rdg(input logic [21:0] r, input logic [6:0] slot, input logic [3:0] p, input logic f,
                     input logic [6:0] nx);
    seq.reading(test_result_type'(r), slot);
    #1;
    check("port", 32'(port_pattern_value_o), 32'(p));
    check("fail", 32'(result_fail_o), 32'(f));
    check("next slot", 32'(next_slot_o), 32'(nx));
  endtask : rdg
  task automatic t_reset;
    #1;
    check("port at reset", 32'(port_pattern_value_o), 32'h0);
    reg_rd("ctrl", `OFF_CTRL, 32'h0);
    reg_rd("fail slot", `OFF_FAIL_SLOT, 32'h0);
    reg_wr(8'h30, 32'hF);
    reg_rd("unmapped", 8'h30, 32'h0);
    reg_rd("pass pattern", `OFF_PASS_PAT, 32'h0);
    reg_wr(`OFF_FAIL_PAT, 32'hE);
    reg_rd("fail pattern", `OFF_FAIL_PAT, 32'hE);
  endtask : t_reset
  task automatic t_grading;
    reg_wr(`OFF_CTRL, 32'hF4);
    reg_wr(`OFF_PASS_PAT, 32'h5);
    reg_wr(`OFF_COMPL_PAT, 32'h6);
    reg_wr(`OFF_CONTACT_PAT, 32'h3);
    reg_wr(`OFF_BAND_BASE, 32'hA9);
    reg_wr(8'h44, 32'hCB);
    reg_wr(`OFF_DEFAULT_LVL, 32'(dflt));
    clear_port();
    rdg(22'h000000, 7'h0A, 4'h5, 1'b0, 7'h0B);
    rdg(22'h100400, 7'h0B, 4'h6, 1'b1, 7'h0C);
    rdg(22'h200000, 7'h0C, 4'h6, 1'b1, 7'h0D);
    clear_port();
    rdg(22'h001001, 7'h14, 4'hA, 1'b1, 7'h15);
    clear_port();
    rdg(22'h200002, 7'h1E, 4'h3, 1'b1, 7'h1F);
    clear_port();
    rdg(22'h001000, 7'h1E, 4'h5, 1'b0, 7'h1F);
    rdg(22'h000002, 7'h1F, 4'hC, 1'b1, 7'h20);
    reg_wr(`OFF_CTRL, 32'hF0);
    reg_wr(`OFF_PASS_PAT, 32'hD);
    clear_port();
    rdg(22'h000000, 7'h05, 4'h5, 1'b0, 7'h06);
    reg_wr(`OFF_PASS_PAT, 32'h5);
  endtask : t_grading
  task automatic t_sorting;
    logic [21:0] rv [5] = '{22'h000400, 22'h000000, 22'h001402, 22'h100000, 22'h200000};
    logic [3:0]  ep [5] = '{4'h2, 4'h1, 4'hE, 4'h6, 4'h3};
    logic        ef [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    reg_wr(`OFF_CTRL, 32'h1FD);
    reg_wr(`OFF_BAND_BASE, 32'hF1);
    reg_wr(8'h44, 32'hF2);
    reg_wr(8'h48, 32'hF4);
    for (int i = 0; i < 5; i++) begin
      restart(dflt);
      rdg(rv[i], 7'h01, ep[i], ef[i], 7'h02);
    end
    reg_wr(`OFF_CTRL, 32'h1F5);
    restart(4'h3);
    reg_wr(`OFF_CTRL, 32'h2D);
    restart(dflt);
    rdg(22'h000000, 7'h02, 4'h5, 1'b0, 7'h03);
    reg_wr(`OFF_CTRL, 32'h1D);
    restart(dflt);
    rdg(22'h000000, 7'h03, 4'h5, 1'b0, 7'h04);
  endtask : t_sorting
  task automatic t_end;
    reg_wr(`OFF_CTRL, 32'h66);
    clear_port();
    rdg(22'h000000, 7'h01, dflt, 1'b0, 7'h02);
    rdg(22'h100000, 7'h02, dflt, 1'b1, 7'h03);
    rdg(22'h000000, 7'h03, dflt, 1'b0, 7'h04);
    seq.pulse(1'b1);
    settle_port("port at sweep end", 4'h6);
    clear_port();
    rdg(22'h000000, 7'h04, dflt, 1'b0, 7'h05);
    seq.pulse(1'b1);
    settle_port("port at sweep end", 4'h5);
  endtask : t_end
  task automatic t_branch;
    reg_wr(`OFF_CTRL, 32'h24);
    clear_port();
    reg_wr(`OFF_PASS_SLOT, 32'h14);
    rdg(22'h000000, 7'h07, 4'h5, 1'b0, 7'h14);
    rdg(22'h100000, 7'h07, 4'h6, 1'b1, 7'h08);
    reg_wr(`OFF_FAIL_SLOT, 32'h32);
    reg_rd("pass slot", `OFF_PASS_SLOT, 32'h0);
    rdg(22'h100000, 7'h09, 4'h6, 1'b1, 7'h32);
    rdg(22'h000000, 7'h09, 4'h6, 1'b0, 7'h0A);
    reg_wr(`OFF_FAIL_SLOT, 32'h65);
    reg_rd("fail slot", `OFF_FAIL_SLOT, 32'h32);
    reg_wr(`OFF_FAIL_SLOT, 32'h0);
    rdg(22'h100000, 7'h63, 4'h6, 1'b1, 7'h64);
    rdg(22'h000000, 7'h64, 4'h6, 1'b0, 7'h65);
  endtask : t_branch
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_grading();
    t_sorting();
    t_end();
    t_branch();
    report_and_stop();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
endmodule : limit_bin_output_tb
`default_nettype wire

// ---- dv/sweep_sequencer_model.sv ----
// Purpose: Sweep sequencer stand-in
// Assumes: Driven through its tasks by the bench
// Notes:   Idle result lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sweep_sequencer_model (
  input  wire logic                     clk_i,
  output logic                          result_valid_o,
  output limit_bin_pkg::test_result_type result_o,
  output logic [6:0]                    cur_slot_o,
  output logic                          seq_start_o,
  output logic                          sweep_end_o
);
  import limit_bin_pkg::*;
  initial begin
    result_valid_o = 1'b0;
    result_o = '0;
    cur_slot_o = 7'h00;
    seq_start_o = 1'b0;
    sweep_end_o = 1'b0;
  end
  // Gap keeps readings clear of bus effects
  task automatic reading(input test_result_type res, input logic [6:0] slot);
    repeat (5) @(posedge clk_i);
    result_valid_o <= 1'b1;
    result_o <= res;
    cur_slot_o <= slot;
    @(posedge clk_i);
    result_valid_o <= 1'b0;
    result_o <= ~res;
    cur_slot_o <= ~slot;
  endtask : reading
  task automatic pulse(input logic is_end);
    repeat (5) @(posedge clk_i);
    if (is_end) sweep_end_o <= 1'b1;
    else seq_start_o <= 1'b1;
    @(posedge clk_i);
    sweep_end_o <= 1'b0;
    seq_start_o <= 1'b0;
  endtask : pulse
endmodule : sweep_sequencer_model
`default_nettype wire

// ---- rtl/branch_selector.sv ----
// Purpose: Next source memory slot after a limit test
// Assumes: Slots 1 to 100, zero target means next slot
// Notes:   Combinational
`timescale 1ns/1ps
`default_nettype none
`include "limit_bin_defs.svh"
module branch_selector (
  input  wire logic [6:0] cur_slot_i,
  input  wire logic       failed_i,
  input  wire logic [6:0] pass_slot_i,
  input  wire logic [6:0] fail_slot_i,
  output logic      [6:0] next_slot_o
);
  always_comb begin
    if (!failed_i && pass_slot_i != `SLOT_NEXT) begin
      next_slot_o = pass_slot_i;
    end else if (failed_i && fail_slot_i != `SLOT_NEXT) begin
      next_slot_o = fail_slot_i;
    end else begin
      next_slot_o = cur_slot_i + 7'h01;
    end
  end
endmodule : branch_selector
`default_nettype wire

// ---- rtl/limit_bin_defs.svh ----
// Purpose: Offsets, fields and reset values
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   Definitions only
`ifndef LIMIT_BIN_DEFS_SVH
`define LIMIT_BIN_DEFS_SVH

`define NUM_BANDS        10
`define OFF_CTRL         8'h00
`define OFF_PASS_PAT     8'h04
`define OFF_FAIL_PAT     8'h08
`define OFF_CONTACT_PAT  8'h0C
`define OFF_COMPL_PAT    8'h10
`define OFF_PASS_SLOT    8'h14
`define OFF_FAIL_SLOT    8'h18
`define OFF_DEFAULT_LVL  8'h1C
`define OFF_CLEAR        8'h20
`define OFF_STATUS       8'h24
`define OFF_BAND_BASE    8'h40
`define OFF_BAND_LAST    8'h64

`define CTRL_SORT_BIT    0
`define CTRL_END_BIT     1
`define CTRL_WIDE_BIT    2
`define CTRL_AUTO_BIT    3
`define CTRL_CONTACT_BIT 4
`define CTRL_COMPL_BIT   5
`define CTRL_BAND_LSB    6
`define CTRL_BAND_MSB    15
`define CTRL_RESET       16'h0000

`define SLOT_NEXT        7'h00
`define SLOT_MAX         7'h64
`define PAT_RESET        4'h0
`define DEFAULT_LVL_RST  4'h0

`endif

// ---- rtl/limit_bin_output.sv ----
// Purpose: Limit test result logic for the handler port
// Assumes: AHB-Lite register slave, zero wait states, single clock
// Notes:   Grading and sorting modes, immediate or end-of-sweep update
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "limit_bin_defs.svh"
module limit_bin_output (
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           hsel_i,
  input  wire logic [31:0]                    haddr_i,
  input  wire logic [1:0]                     htrans_i,
  input  wire logic                           hwrite_i,
  input  wire logic [2:0]                     hsize_i,
  input  wire logic [31:0]                    hwdata_i,
  input  wire logic                           hready_i,
  output logic      [31:0]                    hrdata_o,
  output logic                                hreadyout_o,
  output logic                                hresp_o,
  input  wire logic                           result_valid_i,
  input  wire limit_bin_pkg::test_result_type result_i,
  input  wire logic [6:0]                     cur_slot_i,
  input  wire logic                           seq_start_i,
  input  wire logic                           sweep_end_i,
  output logic      [3:0]                     port_pattern_value_o,
  output logic      [6:0]                     next_slot_o,
  output logic                                next_slot_valid_o,
  output logic                                result_fail_o
);
  import limit_bin_pkg::*;

  logic [15:0]         ctrl_reg;
  logic [3:0]          pass_pat_reg;
  logic [3:0]          fail_pat_reg;
  logic [3:0]          contact_pat_reg;
  logic [3:0]          compl_pat_reg;
  logic [6:0]          pass_slot_reg;
  logic [6:0]          fail_slot_reg;
  logic [3:0]          default_lvl_reg;
  logic [7:0]          band_pat_reg [0:9];
  logic [79:0]         band_pat_flat;
  logic                wr_pend_reg;
  logic [7:0]          addr_reg;
  logic                clear_req;
  logic                clear_now;
  eval_cfg_type        cfg;
  verdict_type         verdict;
  logic [6:0]          branch_next;
  port_state_type      state_reg;
  logic                fail_seen_reg;
  logic                result_seen_reg;
  logic [3:0]          pending_pat_reg;
  logic [3:0]          port_reg;
  logic [31:0]         rdata_next;
  logic [6:0]          wslot;

  function automatic logic is_band(input logic [7:0] a);
    is_band = (a >= `OFF_BAND_BASE) && (a <= `OFF_BAND_LAST) && (a[1:0] == 2'b00);
  endfunction : is_band

  function automatic logic [3:0] band_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFF_BAND_BASE;
    band_index = d[5:2];
  endfunction : band_index

  // AHB address phase capture; data phase follows next cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else if (hready_i) begin
      wr_pend_reg <= hsel_i && htrans_i[1] && hwrite_i;
      addr_reg    <= haddr_i[7:0];
    end
  end

  // Zero wait state slave; always OKAY
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  assign wslot = hwdata_i[6:0];

  // Control and pattern registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg        <= `CTRL_RESET;
      pass_pat_reg    <= `PAT_RESET;
      fail_pat_reg    <= `PAT_RESET;
      contact_pat_reg <= `PAT_RESET;
      compl_pat_reg   <= `PAT_RESET;
      default_lvl_reg <= `DEFAULT_LVL_RST;
      for (int k = 0; k < `NUM_BANDS; k++) begin
        band_pat_reg[k] <= 8'h00;
      end
    end else if (wr_pend_reg) begin
      case (addr_reg)
        `OFF_CTRL:        ctrl_reg        <= hwdata_i[15:0];
        `OFF_PASS_PAT:    pass_pat_reg    <= hwdata_i[3:0];
        `OFF_FAIL_PAT:    fail_pat_reg    <= hwdata_i[3:0];
        `OFF_CONTACT_PAT: contact_pat_reg <= hwdata_i[3:0];
        `OFF_COMPL_PAT:   compl_pat_reg   <= hwdata_i[3:0];
        `OFF_DEFAULT_LVL: default_lvl_reg <= hwdata_i[3:0];
        default: begin
          if (is_band(addr_reg)) begin
            band_pat_reg[band_index(addr_reg)] <= hwdata_i[7:0];
          end
        end
      endcase
    end
  end

  // Branch targets; setting one cancels the other so both never act
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pass_slot_reg <= `SLOT_NEXT;
      fail_slot_reg <= `SLOT_NEXT;
    end else if (wr_pend_reg && hwdata_i[31:7] == 25'h0000000 && wslot <= `SLOT_MAX) begin
      if (addr_reg == `OFF_PASS_SLOT) begin
        pass_slot_reg <= wslot;
        if (wslot != `SLOT_NEXT) begin
          fail_slot_reg <= `SLOT_NEXT;
        end
      end else if (addr_reg == `OFF_FAIL_SLOT) begin
        fail_slot_reg <= wslot;
        if (wslot != `SLOT_NEXT) begin
          pass_slot_reg <= `SLOT_NEXT;
        end
      end
    end
  end

  // Manual clear, or auto-clear on start of a new sequence
  assign clear_req = wr_pend_reg && (addr_reg == `OFF_CLEAR) && hwdata_i[0];
  assign clear_now = clear_req || (seq_start_i && ctrl_reg[`CTRL_AUTO_BIT]);

  always_comb begin
    for (int b = 0; b < `NUM_BANDS; b++) begin
      band_pat_flat[8*b +: 8] = band_pat_reg[b];
    end
  end

  assign cfg.sort_mode  = ctrl_reg[`CTRL_SORT_BIT];
  assign cfg.wide       = ctrl_reg[`CTRL_WIDE_BIT];
  assign cfg.contact_en = ctrl_reg[`CTRL_CONTACT_BIT];
  assign cfg.compl_en   = ctrl_reg[`CTRL_COMPL_BIT];
  assign cfg.band_en    = ctrl_reg[`CTRL_BAND_MSB:`CTRL_BAND_LSB];

  limit_evaluator u_eval (
    .cfg_i         (cfg),
    .res_i         (result_i),
    .pass_pat_i    (pass_pat_reg),
    .fail_pat_i    (fail_pat_reg),
    .contact_pat_i (contact_pat_reg),
    .compl_pat_i   (compl_pat_reg),
    .band_pat_i    (band_pat_flat),
    .verdict_o     (verdict)
  );

  branch_selector u_branch (
    .cur_slot_i  (cur_slot_i),
    .failed_i    (verdict.failed),
    .pass_slot_i (pass_slot_reg),
    .fail_slot_i (fail_slot_reg),
    .next_slot_o (branch_next)
  );

  // Sticky result flags; a reading in the clear cycle still counts
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fail_seen_reg   <= 1'b0;
      result_seen_reg <= 1'b0;
      pending_pat_reg <= `PAT_RESET;
    end else if (result_valid_i) begin
      result_seen_reg <= 1'b1;
      if (verdict.failed) begin
        fail_seen_reg <= 1'b1;
      end else if (clear_now) begin
        fail_seen_reg <= 1'b0;
      end
      // First failure since clear is kept
      if (clear_now || !fail_seen_reg) begin
        pending_pat_reg <= verdict.pattern;
      end
    end else if (clear_now) begin
      fail_seen_reg   <= 1'b0;
      result_seen_reg <= 1'b0;
      pending_pat_reg <= `PAT_RESET;
    end
  end

  // Port state: default, held, or armed for sweep end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= PORT_DEFAULT;
    end else begin
      case (state_reg)
        PORT_DEFAULT, PORT_HOLD: begin
          if (result_valid_i && ctrl_reg[`CTRL_END_BIT]) begin
            state_reg <= PORT_ARMED;
          end else if (result_valid_i) begin
            state_reg <= PORT_HOLD;
          end else if (clear_now) begin
            state_reg <= PORT_DEFAULT;
          end
        end
        PORT_ARMED: begin
          if (sweep_end_i) begin
            state_reg <= PORT_HOLD;
          end else if (clear_now && !result_valid_i) begin
            state_reg <= PORT_DEFAULT;
          end
        end
        default: state_reg <= PORT_DEFAULT;
      endcase
    end
  end

  // Output port; bit n drives line n+1, high when set
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_reg <= `DEFAULT_LVL_RST;
    end else if (result_valid_i && !ctrl_reg[`CTRL_END_BIT] && (clear_now || !fail_seen_reg)) begin
      port_reg <= verdict.pattern;
    end else if (state_reg == PORT_ARMED && sweep_end_i) begin
      port_reg <= pending_pat_reg;
    end else if (clear_now && !result_valid_i) begin
      port_reg <= default_lvl_reg;
    end
    // Otherwise the port holds its pattern
  end

  assign port_pattern_value_o = port_reg;

  // Branch result for the sweep sequencer, one pulse per reading
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      next_slot_o       <= 7'h00;
      next_slot_valid_o <= 1'b0;
      result_fail_o     <= 1'b0;
    end else begin
      next_slot_valid_o <= result_valid_i;
      if (result_valid_i) begin
        next_slot_o   <= branch_next;
        result_fail_o <= verdict.failed;
      end
    end
  end

  // Read mux on the address phase; unmapped words read zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (haddr_i[7:0])
      `OFF_CTRL:        rdata_next[15:0] = ctrl_reg;
      `OFF_PASS_PAT:    rdata_next[3:0]  = pass_pat_reg;
      `OFF_FAIL_PAT:    rdata_next[3:0]  = fail_pat_reg;
      `OFF_CONTACT_PAT: rdata_next[3:0]  = contact_pat_reg;
      `OFF_COMPL_PAT:   rdata_next[3:0]  = compl_pat_reg;
      `OFF_PASS_SLOT:   rdata_next[6:0]  = pass_slot_reg;
      `OFF_FAIL_SLOT:   rdata_next[6:0]  = fail_slot_reg;
      `OFF_DEFAULT_LVL: rdata_next[3:0]  = default_lvl_reg;
      `OFF_STATUS:      rdata_next[8:0]  = {state_reg, result_seen_reg, fail_seen_reg, 1'b0, port_reg};
      default: begin
        if (is_band(haddr_i[7:0])) begin
          rdata_next[7:0] = band_pat_reg[band_index(haddr_i[7:0])];
        end
      end
    endcase
  end

  // Read data is registered so hrdata comes from a flip-flop
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= rdata_next; // Stands through the data phase
    end
  end

endmodule : limit_bin_output
`default_nettype wire

// ---- rtl/limit_bin_pkg.sv ----
// Purpose: Types shared by the limit bin output block
// Assumes: Ten band tests (limits 2, 3, 5 to 12)
// Notes:   Constants live in limit_bin_defs.svh
package limit_bin_pkg;

  typedef struct packed {
    logic       contact_fail;
    logic       compl_fail;
    logic [9:0] low_fail;
    logic [9:0] high_fail;
  } test_result_type;

  typedef struct packed {
    logic       sort_mode;
    logic       wide;
    logic       contact_en;
    logic       compl_en;
    logic [9:0] band_en;
  } eval_cfg_type;

  typedef struct packed {
    logic       failed;
    logic [3:0] pattern;
  } verdict_type;

  typedef enum logic [1:0] {
    PORT_DEFAULT = 2'b00,
    PORT_HOLD    = 2'b01,
    PORT_ARMED   = 2'b10
  } port_state_type;

endpackage : limit_bin_pkg

// ---- rtl/limit_evaluator.sv ----
// Purpose: Picks the pass or fail pattern for one reading
// Assumes: Results valid when the caller samples
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module limit_evaluator (
  input  wire limit_bin_pkg::eval_cfg_type    cfg_i,
  input  wire limit_bin_pkg::test_result_type res_i,
  input  wire logic [3:0]                     pass_pat_i,
  input  wire logic [3:0]                     fail_pat_i,
  input  wire logic [3:0]                     contact_pat_i,
  input  wire logic [3:0]                     compl_pat_i,
  input  wire logic [79:0]                    band_pat_i,
  output limit_bin_pkg::verdict_type          verdict_o
);
  import limit_bin_pkg::*;

  function automatic logic [3:0] width_mask(input logic [3:0] p, input logic wide);
    width_mask = wide ? p : {1'b0, p[2:0]};
  endfunction : width_mask

  logic       found;
  logic [3:0] pat;
  logic       fail;
  integer     i;

  always_comb begin
    found = 1'b0;
    pat   = pass_pat_i;
    fail  = 1'b0;
    // Contact first, then compliance, then bands in order
    if (cfg_i.contact_en && res_i.contact_fail) begin
      found = 1'b1;
      fail  = 1'b1;
      pat   = contact_pat_i;
    end else if (cfg_i.compl_en && res_i.compl_fail) begin
      found = 1'b1;
      fail  = 1'b1;
      pat   = compl_pat_i;
    end else if (!cfg_i.sort_mode) begin
      for (i = 0; i < 10; i++) begin
        if (!found && cfg_i.band_en[i] && res_i.low_fail[i]) begin
          found = 1'b1;
          fail  = 1'b1;
          pat   = band_pat_i[8*i +: 4];
        end else if (!found && cfg_i.band_en[i] && res_i.high_fail[i]) begin
          found = 1'b1;
          fail  = 1'b1;
          pat   = band_pat_i[8*i+4 +: 4];
        end
      end
      // No failure leaves the composite pass pattern
    end else if (cfg_i.band_en == 10'h000) begin
      pat = pass_pat_i;
    end else begin
      for (i = 0; i < 10; i++) begin
        if (!found && cfg_i.band_en[i] && !res_i.low_fail[i] && !res_i.high_fail[i]) begin
          found = 1'b1;
          pat   = band_pat_i[8*i +: 4];
        end
      end
      if (!found) begin
        fail = 1'b1;
        pat  = fail_pat_i;
      end
    end
    verdict_o.failed  = fail;
    verdict_o.pattern = width_mask(pat, cfg_i.wide);
  end

endmodule : limit_evaluator
`default_nettype wire
